// ===== core/ssp_spi_slave.v
`timescale 1ns/100ps
`default_nettype none
`include "ssp_consts.vh"
module ssp_spi_slave #(
  parameter ADDR_W = `SSP_ADDR_W,
  parameter DATA_W = `SSP_DATA_W
) (
  core_clk,
  rst_n,
  protocol_select_pin,
  chip_select_n,
  shared_clock_pin,
  shared_data_pin_in,
  shared_data_pin_out,
  shared_data_pin_oe,
  sdo_out,
  sdo_oe,
  reg_wr_en,
  reg_rd_en,
  reg_addr,
  reg_wdata,
  reg_rdata,
  three_wire_enable
);
  input  wire              core_clk;
  input  wire              rst_n;
  input  wire              protocol_select_pin;
  input  wire              chip_select_n;
  input  wire              shared_clock_pin;
  input  wire              shared_data_pin_in;
  output reg               shared_data_pin_out;
  output reg               shared_data_pin_oe;
  output reg               sdo_out;
  output reg               sdo_oe;
  output reg               reg_wr_en;
  output reg               reg_rd_en;
  output reg  [ADDR_W-1:0] reg_addr;
  output reg  [DATA_W-1:0] reg_wdata;
  input  wire [DATA_W-1:0] reg_rdata;
  output reg               three_wire_enable;

  localparam ST_IDLE = 2'h0;
  localparam ST_CTRL = 2'h1;
  localparam ST_WR   = 2'h2;
  localparam ST_RD   = 2'h3;

  // Pins gathered into one bus for the sampler loop
  wire [`SSP_PIN_CNT-1:0] pin_raw;
  wire [`SSP_PIN_CNT-1:0] pin_s;
  wire                    ps_s;
  wire                    cs_n_s;
  wire                    sck_s;
  wire                    sdi_s;

  assign pin_raw = {shared_data_pin_in, shared_clock_pin, chip_select_n, protocol_select_pin};
  assign ps_s    = pin_s[`SSP_PIN_PS];
  assign cs_n_s  = pin_s[`SSP_PIN_CS];
  assign sck_s   = pin_s[`SSP_PIN_SCK];
  assign sdi_s   = pin_s[`SSP_PIN_SDI];

  // Deselected and non-SPI levels until the pins are seen
  localparam [`SSP_PIN_CNT-1:0] PIN_RST = `SSP_PIN_RST_VAL;

  genvar gi;
  generate
    for (gi = 0; gi < `SSP_PIN_CNT; gi = gi + 1) begin : g_sync
      ssp_sync #(
        .RESET_VAL (PIN_RST[gi])
      ) u_sync (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_in    (pin_raw[gi]),
        .level_out (pin_s[gi])
      );
    end
  endgenerate

  // Frame engine registers
  reg [1:0]                state_r;
  reg                      sck_d_r;
  reg                      cs_d_r;
  reg                      cpol_r;
  reg [`SSP_BIT_CNT_W-1:0] bit_cnt_r;
  reg [DATA_W-1:0]         shift_r;
  reg [DATA_W-1:0]         tx_r;
  reg                      no_inc_r;
  reg                      rd_pend_r;
  reg                      rd_wait_r;

  // Next values
  reg [1:0]                state_nxt;
  reg                      sck_d_nxt;
  reg                      cs_d_nxt;
  reg                      cpol_nxt;
  reg [`SSP_BIT_CNT_W-1:0] bit_cnt_nxt;
  reg [DATA_W-1:0]         shift_nxt;
  reg [DATA_W-1:0]         tx_nxt;
  reg                      no_inc_nxt;
  reg                      rd_pend_nxt;
  reg                      rd_wait_nxt;
  reg                      sd_out_nxt;
  reg                      sd_oe_nxt;
  reg                      sdo_out_nxt;
  reg                      sdo_oe_nxt;
  reg                      wr_en_nxt;
  reg                      rd_en_nxt;
  reg [ADDR_W-1:0]         addr_nxt;
  reg [DATA_W-1:0]         wdata_nxt;
  reg                      three_nxt;

  // Edge and frame events
  wire spi_sel   = (ps_s == `SSP_PROTO_SPI);
  wire active    = spi_sel && !cs_n_s;
  wire cs_fall   = cs_d_r && !cs_n_s;
  wire sck_rise  = !sck_d_r && sck_s;
  wire sck_fall  = sck_d_r && !sck_s;
  // Mode 00 idles low, mode 11 idles high; either way sample on rise
  wire sample_ev = sck_rise;
  wire [DATA_W-1:0] shift_in = {shift_r[DATA_W-2:0], sdi_s};
  wire ctrl_end  = (bit_cnt_r == `SSP_CTRL_BITS - 1'b1);
  wire byte_end  = (bit_cnt_r[2:0] == `SSP_BYTE_LAST);

  // Next-state logic of the frame engine
  always @* begin
    state_nxt   = state_r;
    sck_d_nxt   = sck_s;
    cs_d_nxt    = cs_n_s;
    cpol_nxt    = cpol_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    tx_nxt      = tx_r;
    no_inc_nxt  = no_inc_r;
    rd_pend_nxt = 1'b0;
    rd_wait_nxt = rd_pend_r;
    sd_out_nxt  = shared_data_pin_out;
    sd_oe_nxt   = shared_data_pin_oe;
    sdo_out_nxt = sdo_out;
    sdo_oe_nxt  = sdo_oe;
    wr_en_nxt   = 1'b0;
    rd_en_nxt   = 1'b0;
    addr_nxt    = reg_addr;
    wdata_nxt   = reg_wdata;
    three_nxt   = three_wire_enable;

    // Read data is valid the cycle after the strobe cycle
    if (rd_wait_r) begin
      tx_nxt = reg_rdata;
    end

    if (!active) begin
      state_nxt   = ST_IDLE;
      bit_cnt_nxt = {`SSP_BIT_CNT_W{1'b0}};
      sdo_oe_nxt  = 1'b0;
      sd_oe_nxt   = 1'b0;
    end else if (cs_fall) begin
      cpol_nxt    = sck_s;
      state_nxt   = ST_CTRL;
      bit_cnt_nxt = {`SSP_BIT_CNT_W{1'b0}};
    end else begin
      if (sample_ev && state_r != ST_IDLE) begin
        shift_nxt   = shift_in;
        bit_cnt_nxt = bit_cnt_r + 1'b1;
        case (state_r)
          ST_CTRL: begin
            if (ctrl_end) begin
              addr_nxt    = shift_in[ADDR_W-1:0];
              no_inc_nxt  = (shift_in[ADDR_W-1:0] == `SSP_FIFO_REG_ADDR);
              bit_cnt_nxt = {`SSP_BIT_CNT_W{1'b0}};
              if (shift_in[DATA_W-1] == `SSP_DIR_READ) begin
                state_nxt   = ST_RD;
                rd_en_nxt   = 1'b1;
                rd_pend_nxt = 1'b1;
              end else begin
                state_nxt = ST_WR;
              end
            end
          end
          ST_WR: begin
            if (byte_end) begin
              wdata_nxt = shift_in;
              wr_en_nxt = 1'b1;
              state_nxt = ST_IDLE;
              if (reg_addr == `SSP_CFG_REG_ADDR) begin
                three_nxt = shift_in[`SSP_THREE_WIRE_BIT];
              end
            end
          end
          ST_RD: begin
            if (byte_end) begin
              bit_cnt_nxt = {`SSP_BIT_CNT_W{1'b0}};
              if (!no_inc_r) begin
                addr_nxt = reg_addr + 1'b1;
              end
              rd_en_nxt   = 1'b1;
              rd_pend_nxt = 1'b1;
            end
          end
          default: begin
            state_nxt = ST_IDLE;
          end
        endcase
      end

      // Read data launched on falling edges, MSB first
      if (state_r == ST_RD && sck_fall) begin
        sdo_out_nxt = tx_r[DATA_W-1];
        sd_out_nxt  = tx_r[DATA_W-1];
        tx_nxt      = {tx_r[DATA_W-2:0], 1'b0};
        if (three_wire_enable) begin
          sd_oe_nxt  = 1'b1;
          sdo_oe_nxt = 1'b0;
        end else begin
          sdo_oe_nxt = 1'b1;
          sd_oe_nxt  = 1'b0;
        end
      end

      // Outputs stay released outside read data
      if (state_r != ST_RD) begin
        sdo_oe_nxt = 1'b0;
        sd_oe_nxt  = 1'b0;
      end
    end
  end

  // Pin edge trackers and mode capture
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
      cpol_r  <= 1'b0;
    end else begin
      sck_d_r <= sck_d_nxt;
      cs_d_r  <= cs_d_nxt;
      cpol_r  <= cpol_nxt;
    end
  end

  // Frame engine state
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= {`SSP_BIT_CNT_W{1'b0}};
      shift_r   <= {DATA_W{1'b0}};
      tx_r      <= {DATA_W{1'b0}};
      no_inc_r  <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r   <= shift_nxt;
      tx_r      <= tx_nxt;
      no_inc_r  <= no_inc_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_wait_r <= rd_wait_nxt;
    end
  end

  // Serial data outputs
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shared_data_pin_out <= 1'b0;
      shared_data_pin_oe  <= 1'b0;
      sdo_out             <= 1'b0;
      sdo_oe              <= 1'b0;
    end else begin
      shared_data_pin_out <= sd_out_nxt;
      shared_data_pin_oe  <= sd_oe_nxt;
      sdo_out             <= sdo_out_nxt;
      sdo_oe              <= sdo_oe_nxt;
    end
  end

  // Register access side
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_en         <= 1'b0;
      reg_rd_en         <= 1'b0;
      reg_addr          <= {ADDR_W{1'b0}};
      reg_wdata         <= {DATA_W{1'b0}};
      three_wire_enable <= 1'b0;
    end else begin
      reg_wr_en         <= wr_en_nxt;
      reg_rd_en         <= rd_en_nxt;
      reg_addr          <= addr_nxt;
      reg_wdata         <= wdata_nxt;
      three_wire_enable <= three_nxt;
    end
  end

endmodule // ssp_spi_slave
`default_nettype wire

// ===== core/ssp_consts.vh
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH
`define SSP_FRAME_BITS      5'h10
`define SSP_CTRL_BITS       5'h08
`define SSP_BYTE_LAST       3'h7
`define SSP_BIT_CNT_W       5
`define SSP_ADDR_W          7
`define SSP_DATA_W          8
`define SSP_CFG_REG_ADDR    7'h34
`define SSP_THREE_WIRE_BIT  2
`define SSP_FIFO_REG_ADDR   7'h3F
`define SSP_DIR_READ        1'b1
`define SSP_PROTO_SPI       1'b0
`define SSP_PIN_CNT         4
`define SSP_PIN_RST_VAL     4'h3
`define SSP_PIN_PS          0
`define SSP_PIN_CS          1
`define SSP_PIN_SCK         2
`define SSP_PIN_SDI         3
`endif

// ===== core/ssp_sync.v
`timescale 1ns/100ps
`default_nettype none
// Three-stage sampler; a change is accepted once stages two and three agree
module ssp_sync #(
  parameter RESET_VAL = 1'b0
) (
  core_clk,
  rst_n,
  pin_in,
  level_out
);
  input  wire core_clk;
  input  wire rst_n;
  input  wire pin_in;
  output reg  level_out;

  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r      <= RESET_VAL;
      s2_r      <= RESET_VAL;
      s3_r      <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule // ssp_sync
`default_nettype wire

// ===== tb/ssp_spi_slave_props.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_spi_slave_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic protocol_select_pin,
  input wire logic chip_select_n,
  input wire logic sdo_oe,
  input wire logic shared_data_pin_oe,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic three_wire_enable
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cs_idle;
    chip_select_n [*8];
  endsequence
  sequence s_ps_off;
    protocol_select_pin [*8];
  endsequence
  a_wr_pulse_one: assert property (reg_wr_en |=> !reg_wr_en)
    else $error("write strobe longer than one cycle");
  a_rd_pulse_one: assert property (reg_rd_en |=> !reg_rd_en)
    else $error("read strobe longer than one cycle");
  a_idle_no_access: assert property (s_cs_idle |-> !reg_wr_en && !reg_rd_en)
    else $error("access while deselected");
  a_idle_release: assert property (s_cs_idle |-> !sdo_oe && !shared_data_pin_oe)
    else $error("data driven while deselected");
  a_ps_off_quiet: assert property (s_ps_off |-> !reg_wr_en && !sdo_oe)
    else $error("port active with other protocol");
  a_oe_exclusive: assert property (!(sdo_oe && shared_data_pin_oe))
    else $error("both data outputs driven");
  a_three_pin: assert property (shared_data_pin_oe |-> three_wire_enable)
    else $error("shared pin driven in four-wire");
  a_four_pin: assert property (sdo_oe |-> !three_wire_enable)
    else $error("output pin driven in three-wire");
endmodule // ssp_spi_slave_props
bind ssp_spi_slave ssp_spi_slave_props i_props (.core_clk, .rst_n, .protocol_select_pin,
  .chip_select_n, .sdo_oe, .shared_data_pin_oe, .reg_wr_en, .reg_rd_en, .three_wire_enable);
`default_nettype wire

// ===== tb/ssp_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_master_model (
  output logic        cs_n,
  output logic        sck,
  output logic        mosi,
  output logic        m_oe,
  input  wire logic   miso,
  output logic [31:0] rx
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    mosi = 1'b0;
    m_oe = 1'b1;
    rx = 32'h0;
  end
  task automatic xfer(input logic cpol, input int n, input int n_out, input logic [31:0] tx);
    sck = cpol;
    #107 cs_n = 1'b0;
    #400;
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      m_oe = (i < n_out);
      if (i < n_out) mosi = tx[31-i];
      #250 sck = 1'b1;
      rx = {rx[30:0], miso};
      #150;
    end
    sck = cpol;
    #200 cs_n = 1'b1;
    m_oe = 1'b1;
    #2000;
  endtask
endmodule // ssp_master_model
`default_nettype wire

// ===== tb/ssp_spi_slave_test.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_spi_slave_test;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ps = 1'b0;
  logic [7:0]  reg_rdata = 8'h00;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [14:0] w_rec;
  logic        cs_n, sck, mosi, m_oe, sd_out, sd_oe, sdo, sdo_oe, wr_en, rd_en, three;
  logic [31:0] rx;
  int          bad_count = 0, comparisons = 0, wr_cnt = 0, cyc = 0, oe_hits = 0;
  wire         sd_line = sd_oe ? sd_out : (m_oe ? mosi : ~mosi);
  wire         miso = three ? sd_line : (sdo_oe ? sdo : ~sdo);
  always #25 core_clk = ~core_clk;
  ssp_spi_slave i_dut (.core_clk, .rst_n, .protocol_select_pin(ps), .chip_select_n(cs_n),
    .shared_clock_pin(sck), .shared_data_pin_in(sd_line), .shared_data_pin_out(sd_out),
    .shared_data_pin_oe(sd_oe), .sdo_out(sdo), .sdo_oe, .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr, .reg_wdata, .reg_rdata, .three_wire_enable(three));
  ssp_master_model i_mst (.cs_n, .sck, .mosi, .m_oe, .miso, .rx);
  function automatic logic [7:0] rv(input logic [6:0] a);
    rv = {1'b0, a} ^ 8'h5A;
  endfunction
  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    reg_rdata <= rv(reg_addr);
    if (wr_en) wr_cnt <= wr_cnt + 1;
    if (wr_en) w_rec <= {reg_addr, reg_wdata};
    if (sdo_oe) oe_hits <= oe_hits + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic t_write(input logic m, input logic [6:0] a, input logic [7:0] d);
    int n0, o0;
    n0 = wr_cnt;
    o0 = oe_hits;
    i_mst.xfer(m, 16, 16, {1'b0, a, d, 16'h0});
    chk(wr_cnt - n0, 1);
    chk(w_rec, {a, d});
    chk(oe_hits - o0, 0);
  endtask
  task automatic t_read(input logic m, input logic [6:0] a, input logic [23:0] e);
    i_mst.xfer(m, 32, 8, {1'b1, a, 24'h0});
    chk(rx[23:0], e);
  endtask
  task automatic t_skip(input int bits);
    int n0;
    n0 = wr_cnt;
    i_mst.xfer(1'b1, bits, bits, {1'b0, 7'h11, 8'hFF, 16'h0});
    chk(wr_cnt - n0, 0);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(three, 0);
    t_write(1'b1, 7'h12, 8'hC3);
    t_write(1'b0, 7'h2B, 8'h3C);
    t_skip(12);
    t_read(1'b1, 7'h02, {rv(7'h02), rv(7'h03), rv(7'h04)});
    t_read(1'b0, 7'h3F, {3{rv(7'h3F)}});
    @(posedge core_clk) ps <= 1'b1;
    t_skip(16);
    @(posedge core_clk) ps <= 1'b0;
    t_write(1'b1, 7'h34, 8'h04);
    chk(three, 1);
    t_read(1'b1, 7'h10, {rv(7'h10), rv(7'h11), rv(7'h12)});
    close_out();
  end
endmodule // ssp_spi_slave_test
`default_nettype wire
